// >>> src/ptt_pkg.sv
// Constants for the periodic tick timer: register offsets, field positions, reset values.
// Assumes a 32-bit word-wide private peripheral register port inside the core.
package ptt_pkg;

	// ============================================================
	// Register map
	localparam logic [11:0] PTT_BASE_OFFSET    = 12'h000;
	localparam logic [11:0] PTT_OFF_CTRL       = 12'h010;
	localparam logic [11:0] PTT_OFF_RELOAD     = 12'h014;
	localparam logic [11:0] PTT_OFF_CURRENT    = 12'h018;
	localparam logic [11:0] PTT_OFF_CALIB      = 12'h01C;

	// ============================================================
	// Field layout
	localparam int          PTT_CNT_W          = 24;
	localparam int          PTT_BIT_ENABLE     = 0;
	localparam int          PTT_BIT_IRQ_EN     = 1;
	localparam int          PTT_BIT_CLK_SEL    = 2;
	localparam int          PTT_BIT_ZERO_FLAG  = 16;
	localparam int          PTT_BIT_SKEW       = 30;
	localparam int          PTT_BIT_EXTERNAL_CLOCK_ABSENT      = 31;

	// ============================================================
	// Reset values and counter constants
	localparam logic [23:0] PTT_CNT_RESET      = 24'h000000;
	localparam logic [23:0] PTT_CALIB_RESET    = 24'h000004;
	localparam logic [23:0] PTT_CNT_ZERO       = 24'h000000;
	localparam logic [23:0] PTT_CNT_ONE        = 24'h000001;

endpackage

// >>> src/ptt_timer.sv
// Periodic tick timer: 24-bit down counter with control, reload, current and calibration
// registers. Assumes a simple word bus: one-cycle read and write strobes, synchronous data.
//
// What this block does
// - The counter runs only while the enable bit 0 is one and holds otherwise.
// - With interrupt enable bit 1 set, reaching zero raises the tick interrupt.
// - Clock select bit 2 picks the full clock at one and the clock halved at zero.
// - Status bit 16 shows a zero was reached since the last control read, which clears it.
// - On the tick after reaching zero the counter reloads from the 24-bit reload field.
// - A current-value read returns the present 24-bit count.
// - Any current-value write clears the counter and the zero-reached flag.
// - The calibration register reads the externally supplied setting; the count resets to 0x0.
// - The four registers sit at base plus offsets from 0x010.
`timescale 1ns/1ps

module ptt_timer
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [11:0] bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [31:0] bus_wdata,
	output logic      [31:0] bus_rdata,
	input  wire logic [23:0] system_calibration_source,
	input  wire logic        calib_skew,
	input  wire logic        external_clock_absent,
	output logic             tick_irq
);

	// ============================================================
	// Address decode
	logic        sel_ctrl;
	logic        sel_reload;
	logic        sel_current;
	logic        sel_calib;
	logic [11:0] rel_addr;

	assign rel_addr    = bus_addr - ptt_pkg::PTT_BASE_OFFSET;
	assign sel_ctrl    = (rel_addr == ptt_pkg::PTT_OFF_CTRL);
	assign sel_reload  = (rel_addr == ptt_pkg::PTT_OFF_RELOAD);
	assign sel_current = (rel_addr == ptt_pkg::PTT_OFF_CURRENT);
	assign sel_calib   = (rel_addr == ptt_pkg::PTT_OFF_CALIB);

	// ============================================================
	// State
	logic        enable_reg;
	logic        tick_irq_enable_reg;
	logic        tick_clock_select_reg;
	logic        zero_reached_flag_reg;
	logic [23:0] reload_reg;
	logic [23:0] count_reg;
	logic [23:0] count_next;
	logic        half_reg;
	logic        irq_reg;
	logic        tick_en;
	logic        zero_event;
	logic        cur_write;
	logic        ctrl_read;

	assign cur_write = bus_wr & sel_current;
	assign ctrl_read = bus_rd & sel_ctrl;

	// ============================================================
	// Tick enable: full rate or every second cycle.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			half_reg <= 1'b0;
		else
			half_reg <= ~half_reg;
	end

	assign tick_en = enable_reg & (tick_clock_select_reg | half_reg);

	// A tick while the count sits at one lands on zero; that is the counted-to-zero event.
	assign zero_event = tick_en & ~cur_write & (count_reg == ptt_pkg::PTT_CNT_ONE);

	// A write to the current value wins over a tick in the same cycle.
	assign count_next = cur_write ? ptt_pkg::PTT_CNT_ZERO :
		!tick_en ? count_reg :
		(count_reg == ptt_pkg::PTT_CNT_ZERO) ? reload_reg :
		count_reg - ptt_pkg::PTT_CNT_ONE;

	// ============================================================
	// Registers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			enable_reg            <= 1'b0;
			tick_irq_enable_reg   <= 1'b0;
			tick_clock_select_reg <= 1'b0;
			reload_reg            <= ptt_pkg::PTT_CNT_RESET;
			count_reg             <= ptt_pkg::PTT_CNT_RESET;
		end
		else
		begin
			if (bus_wr & sel_ctrl)
			begin
				enable_reg            <= bus_wdata[ptt_pkg::PTT_BIT_ENABLE];
				tick_irq_enable_reg   <= bus_wdata[ptt_pkg::PTT_BIT_IRQ_EN];
				tick_clock_select_reg <= bus_wdata[ptt_pkg::PTT_BIT_CLK_SEL];
			end
			if (bus_wr & sel_reload)
				reload_reg <= bus_wdata[23:0];
			count_reg <= count_next;
		end
	end

	// Flag: a new zero event wins over a control read that clears it; a current-value write wins over the event.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			zero_reached_flag_reg <= 1'b0;
		else if (zero_event)
			zero_reached_flag_reg <= 1'b1;
		else if (ctrl_read | cur_write)
			zero_reached_flag_reg <= 1'b0;
	end

	// Interrupt is a one-cycle request pulse per zero event while interrupt enable bit 1 is set.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			irq_reg <= 1'b0;
		else
			irq_reg <= zero_event & tick_irq_enable_reg;
	end

	assign tick_irq = irq_reg;

	// ============================================================
	// Read data, registered; reserved bits read as zero.
	logic [31:0] ctrl_word;
	logic [31:0] calib_word;
	logic [31:0] rdata_next;

	assign ctrl_word = {15'h0000, zero_reached_flag_reg, 13'h0000,
		tick_clock_select_reg, tick_irq_enable_reg, enable_reg};
	assign calib_word = {external_clock_absent, calib_skew, 6'h00,
		system_calibration_source};
	assign rdata_next = !bus_rd ? bus_rdata :
		sel_ctrl    ? ctrl_word :
		sel_reload  ? {8'h00, reload_reg} :
		sel_current ? {8'h00, count_reg} :
		sel_calib   ? calib_word :
		32'h00000000;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			bus_rdata <= 32'h00000000;
		else
			bus_rdata <= rdata_next;
	end

endmodule

// >>> verification/ptt_timer_properties.sv
// Checker of the tick timer's register port and tick pulse.
// Assumes it is bound to every ptt_timer instance.
`timescale 1ns/1ps
module ptt_timer_chk
(
	input wire logic		clk_sys,
	input wire logic		rst_b,
	input wire logic [11:0]	bus_addr,
	input wire logic		bus_wr,
	input wire logic		bus_rd,
	input wire logic [31:0]	bus_wdata,
	input wire logic [31:0]	bus_rdata,
	input wire logic [23:0]	system_calibration_source,
	input wire logic		calib_skew,
	input wire logic		external_clock_absent,
	input wire logic		tick_irq
);
	// ====
	// Shadow of the enable bits, since the checker cannot see inside.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [1:0] ctl_reg;
	wire rc = bus_rd && bus_addr == ptt_pkg::PTT_OFF_CTRL;
	wire rk = bus_rd && bus_addr == ptt_pkg::PTT_OFF_CALIB;
	wire wc = bus_wr && bus_addr == ptt_pkg::PTT_OFF_CURRENT;
	wire mp = bus_addr inside {12'h010, 12'h014, 12'h018, 12'h01C};
	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			ctl_reg <= 2'h0;
		else if (bus_wr && bus_addr == ptt_pkg::PTT_OFF_CTRL)
			ctl_reg <= bus_wdata[1:0];
	a_run_enable: assert property (tick_irq |-> ctl_reg[0] || $past(ctl_reg[0]))
		else $error("tick while disabled");
	a_irq_masked: assert property (tick_irq |-> ctl_reg[1] || $past(ctl_reg[1]))
		else $error("tick while masked");
	a_irq_pulse: assert property (tick_irq |=> !tick_irq)
		else $error("tick longer than one cycle");
	a_flag_seen: assert property (tick_irq && rc |=> bus_rdata[16])
		else $error("flag missing at tick");
	a_ctl_reserved: assert property (rc |=> bus_rdata[31:17] == 0 && bus_rdata[15:3] == 0)
		else $error("reserved bits set");
	a_clear_flag: assert property (wc ##1 rc |=> !bus_rdata[16])
		else $error("flag kept after clear");
	a_calib_value: assert property (rk |=> bus_rdata == {$past(external_clock_absent),
		$past(calib_skew), 6'h00, $past(system_calibration_source)})
		else $error("calibration read wrong");
	a_unmapped_zero: assert property (bus_rd && !mp |=> bus_rdata == 0)
		else $error("unmapped read not zero");
endmodule
bind ptt_timer ptt_timer_chk chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.system_calibration_source(system_calibration_source), .calib_skew(calib_skew),
	.external_clock_absent(external_clock_absent), .tick_irq(tick_irq));

// >>> verification/tb_periodic_tick_timer.sv
// Bench of the tick timer: reads checked through a queue, tick periods measured.
// Assumes a read is answered at the edge that takes it.
`timescale 1ns/1ps
module tb_periodic_tick_timer;
	// ====
	logic clk_sys = 0, rst_b = 0, bus_wr = 0, bus_rd = 0, tick_irq, sk = 0, nr = 0;
	logic [11:0] bus_addr = 0;
	logic [31:0] bus_wdata = 0, bus_rdata, rng = 340, cv, qe[$], qm[$];
	logic [23:0] cal = 0, rl;
	int qp[$], n_mismatch = 0, checks_done = 0, cyc = 0, n_irq = 0, k = 0;
	ptt_timer dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .calib_skew(sk),
		.system_calibration_source(cal), .external_clock_absent(nr), .tick_irq(tick_irq));
	always #5 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH bus_rdata expected %h seen %h", e, s);
		end
	endtask
	task automatic cmp_per(input int e, input int s);
		checks_done++;
		if (s != e)
		begin
			n_mismatch++;
			$display("MISMATCH tick period expected %0d seen %0d", e, s);
		end
	endtask
	task automatic drv(input logic w, r, input logic [11:0] a, input logic [31:0] d);
		#1;
		{bus_wr, bus_rd, bus_addr, bus_wdata} = {w, r, a, d};
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
		qe.push_back(e);
		qm.push_back(m);
		drv(0, 1, a, 32'h0);
	endtask
	task automatic wait_irq;
		for (int i = 0; i < 200 && tick_irq !== 1'b1; i++)
			@(posedge clk_sys);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (tick_irq === 1'b1)
		begin
			n_irq++;
			if (qp.size() > 0)
				cmp_per(qp.pop_front(), cyc);
			cyc = 0;
		end
		if (bus_rd)
		begin
			#2;
			cmp_rd(qe.pop_front(), bus_rdata & qm.pop_front());
		end
	end
	initial
	begin
		#100000;
		n_mismatch++;
		results;
	end
	initial
	begin
		cv = xs(rng);
		{sk, nr, cal} = cv[25:0];
		rl = rng[3:0] + 24'h8;
		repeat (4) @(posedge clk_sys);
		#1 rst_b = 1;
		for (int i = 0; i < 3; i++)
			rd(12'h010 + 12'h4 * i, 32'h0, 32'hFFFFFFFF);
		rd(12'h01C, {nr, sk, 6'h00, cal}, 32'hFFFFFFFF);
		rd(12'h020, 32'h0, 32'hFFFFFFFF);
		drv(1, 0, 12'h014, {8'h00, rl});
		rd(12'h014, {8'h00, rl}, 32'hFFFFFFFF);
		for (int s = 1; s >= 0; s--)
		begin
			cv = s ? 32'h7 : 32'h3;
			drv(1, 0, 12'h018, xs(rng));
			drv(1, 0, 12'h010, cv);
			wait_irq;
			drv(0, 0, 12'h0, 32'h0);
			qp.push_back(s ? rl + 1 : 2 * (rl + 1));
			wait_irq;
			repeat (s ? rl : 2 * rl + 1) drv(0, 0, 12'h0, 32'h0);
			rd(12'h010, cv | 32'h10000, 32'hFFFFFFFF);
			rd(12'h010, cv, 32'hFFFFFFFF);
		end
		drv(1, 0, 12'h010, 32'h5);
		k = n_irq;
		repeat (30) drv(0, 0, 12'h0, 32'h0);
		rd(12'h010, 32'h10005, 32'h10007);
		cmp_per(k, n_irq);
		drv(1, 0, 12'h018, xs(rng));
		repeat (3) drv(0, 0, 12'h0, 32'h0);
		rd(12'h018, {8'h00, rl - 24'h2}, 32'hFFFFFFFF);
		drv(1, 0, 12'h010, 32'h0);
		drv(1, 0, 12'h018, xs(rng));
		rd(12'h010, 32'h0, 32'hFFFFFFFF);
		rd(12'h018, 32'h0, 32'hFFFFFFFF);
		repeat (5) drv(0, 0, 12'h0, 32'h0);
		rd(12'h018, 32'h0, 32'hFFFFFFFF);
		drv(0, 0, 12'h0, 32'h0);
		drv(1, 0, 12'h014, {8'h00, cal});
		rd(12'h014, {8'h00, cal}, 32'hFFFFFFFF);
		drv(0, 0, 12'h0, 32'h0);
		cmp_per(0, qp.size());
		results;
	end
endmodule
